// ===== verilog/tsg_pkg.sv
// Package: TAP states, command layout and timing constants of the TMS sequence generator
`default_nettype none

package tsg_pkg;

  // Sixteen TAP controller states
  typedef enum logic [3:0] {
    TAP_RESET                   = 4'h0,
    TAP_IDLE                    = 4'h1,
    TAP_SELECT_DATA_SCAN        = 4'h2,
    TAP_CAPTURE_DR              = 4'h3,
    TAP_SHIFT_DR                = 4'h4,
    TAP_EXIT1_DR                = 4'h5,
    TAP_PAUSE_DR                = 4'h6,
    TAP_EXIT2_DR                = 4'h7,
    TAP_UPDATE_DR               = 4'h8,
    TAP_SELECT_INSTRUCTION_SCAN = 4'h9,
    TAP_CAPTURE_IR              = 4'hA,
    TAP_SHIFT_IR                = 4'hB,
    TAP_EXIT1_IR                = 4'hC,
    TAP_PAUSE_IR                = 4'hD,
    TAP_EXIT2_IR                = 4'hE,
    TAP_UPDATE_IR               = 4'hF
  } tsg_tap_state_type;

  // Command byte layout
  localparam int unsigned CMD_WIDTH              = 8;
  localparam int unsigned CMD_SOFTWARE_RESET_BIT = 7;
  localparam int unsigned CMD_GOAL_MSB           = 2;
  localparam int unsigned CMD_GOAL_LSB           = 0;

  // Goal codes in the command byte
  localparam logic [2:0] GOAL_RESET    = 3'h0;
  localparam logic [2:0] GOAL_IDLE     = 3'h1;
  localparam logic [2:0] GOAL_SHIFT_DR = 3'h2;
  localparam logic [2:0] GOAL_PAUSE_DR = 3'h3;
  localparam logic [2:0] GOAL_SHIFT_IR = 3'h4;
  localparam logic [2:0] GOAL_PAUSE_IR = 3'h5;

  // TMS high edges forced after reset
  localparam logic [2:0] RESET_TMS_EDGES = 3'h5;
  localparam logic [2:0] WAIT_DONE       = 3'h0;
  localparam logic [2:0] WAIT_STEP       = 3'h1;

endpackage : tsg_pkg

`default_nettype wire

// ===== verilog/tsg_tap_model.sv
// TAP controller state model clocked on TCK
`default_nettype none

module tsg_tap_model
  import tsg_pkg::*;
(
  // Link clock and control
  input  wire logic        tck_in,
  input  wire logic        reset_in,
  input  wire logic        enable_in,
  // TMS level sampled at the rising edge
  input  wire logic        tms_in,
  // Present and next state
  output tsg_tap_state_type state_out,
  output tsg_tap_state_type next_state_out
);

  tsg_tap_state_type state_q;

  function automatic tsg_tap_state_type tap_next(input tsg_tap_state_type s, input logic t);
    tsg_tap_state_type n;
    n = TAP_RESET;
    case (s)
      TAP_RESET:                   n = t ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:                    n = t ? TAP_SELECT_DATA_SCAN : TAP_IDLE;
      TAP_SELECT_DATA_SCAN:        n = t ? TAP_SELECT_INSTRUCTION_SCAN : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR:              n = t ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:                n = t ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:                n = t ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:                n = t ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:                n = t ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:               n = t ? TAP_SELECT_DATA_SCAN : TAP_IDLE;
      TAP_SELECT_INSTRUCTION_SCAN: n = t ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR:              n = t ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:                n = t ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:                n = t ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:                n = t ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:                n = t ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:               n = t ? TAP_SELECT_DATA_SCAN : TAP_IDLE;
      default:                     n = TAP_RESET;
    endcase
    return n;
  endfunction

  assign next_state_out = tap_next(state_q, tms_in); // RULE_08
  assign state_out      = state_q;

  // State moves only on a rising TCK edge
  always_ff @(posedge tck_in) begin
    if (reset_in) begin
      state_q <= TAP_RESET;
    end else if (enable_in) begin
      state_q <= next_state_out; // RULE_07
    end
  end

endmodule // tsg_tap_model

`default_nettype wire

// ===== verilog/tsg_tap_state_generator.sv
// TMS sequence generator of a boundary-scan test-bus master
`default_nettype none

// Function
// RULE_01 - From Pause-IR: reset by five highs, idle by HHL, Shift-IR by HL.
// RULE_02 - From Pause-IR: Shift-DR HHHLL, Pause-DR HHHLHL, Pause-IR again HHHHLHL.
// RULE_03 - From Shift-DR: reset by five highs, idle by HHL.
// RULE_04 - From Shift-DR: Pause-DR by HL, Pause-IR by HHHHLHL.
// RULE_05 - From Shift-IR: reset by five highs, idle by HHL.
// RULE_06 - From Shift-IR: Pause-IR by HL, Pause-DR by HHHLHL.
// RULE_07 - TAP state changes only at rising TCK, chosen by sampled TMS.
// RULE_08 - Modelled TAP machine has sixteen states, six stable, ten transient.
// RULE_09 - Target scans instruction register or one data register, never both.
// RULE_10 - Generator enters Test-Logic-Reset on power-up, hardware reset, software reset bit.
// RULE_11 - Target in reset disables test logic, loads IDCODE or BYPASS.
// RULE_12 - Target does nothing in select states and leaves them next cycle.
// RULE_13 - Target captures data register at the edge leaving Capture-DR.
// RULE_14 - Target enables TDO at first falling edge in Shift-DR, shifts LSB first.
// RULE_15 - Target floats TDO at first falling edge after entering Exit1-DR.
// RULE_16 - Target may re-enter Shift-DR from exit states without recapture.
// RULE_17 - Free-running stall parks targets in pause; gated stall holds shift.
// RULE_18 - Discrete mode: TMS follows the host's discrete-control value.
// RULE_19 - After a sequence hold TMS low, or high in Test-Logic-Reset.

module tsg_tap_state_generator
  import tsg_pkg::*;
(
  // Host clock domain
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 ref_clk_en_in,
  // Command port
  input  wire logic                 command_valid_in,
  input  wire logic [CMD_WIDTH-1:0] command_in,
  output logic                      busy_out,
  output logic [3:0]                tap_state_out,
  // Modes and buffer status
  input  wire logic                 discrete_mode_in,
  input  wire logic                 discrete_tms_in,
  input  wire logic                 buffer_stall_in,
  input  wire logic                 gated_tck_mode_in,
  // Link
  input  wire logic                 tck_in,
  output logic                      tms_out
);

  function automatic logic goal_valid(input logic [2:0] g);
    return (g <= GOAL_PAUSE_IR);
  endfunction

  function automatic tsg_tap_state_type goal_state(input logic [2:0] g);
    tsg_tap_state_type s;
    s = TAP_RESET;
    case (g)
      GOAL_RESET:    s = TAP_RESET;
      GOAL_IDLE:     s = TAP_IDLE;
      GOAL_SHIFT_DR: s = TAP_SHIFT_DR;
      GOAL_PAUSE_DR: s = TAP_PAUSE_DR;
      GOAL_SHIFT_IR: s = TAP_SHIFT_IR;
      GOAL_PAUSE_IR: s = TAP_PAUSE_IR;
      default:       s = TAP_RESET;
    endcase
    return s;
  endfunction

  // Next TMS on the way from state s toward goal g; leave forces exit from a goal pause
  function automatic logic route(input tsg_tap_state_type s, input tsg_tap_state_type g, input logic leave);
    logic r;
    r = 1'b1;
    case (g)
      TAP_IDLE:     r = !(s inside {TAP_RESET, TAP_IDLE, TAP_UPDATE_DR, TAP_UPDATE_IR});
      TAP_SHIFT_DR: r = !(s inside {TAP_RESET, TAP_SELECT_DATA_SCAN, TAP_CAPTURE_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
                                    TAP_EXIT2_DR});
      TAP_PAUSE_DR: r = (s == TAP_PAUSE_DR) ? leave
                      : !(s inside {TAP_RESET, TAP_SELECT_DATA_SCAN, TAP_EXIT1_DR});
      TAP_SHIFT_IR: r = !(s inside {TAP_RESET, TAP_SELECT_INSTRUCTION_SCAN, TAP_CAPTURE_IR, TAP_SHIFT_IR,
                                    TAP_EXIT1_IR, TAP_EXIT2_IR});
      TAP_PAUSE_IR: r = (s == TAP_PAUSE_IR) ? leave
                      : !(s inside {TAP_RESET, TAP_SELECT_INSTRUCTION_SCAN, TAP_EXIT1_IR});
      default:      r = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic is_pause(input tsg_tap_state_type s);
    return (s == TAP_PAUSE_DR) || (s == TAP_PAUSE_IR);
  endfunction

  // Host domain signals
  logic       rst_hold_q;
  logic [1:0] ack_sync_q;
  logic [1:0] done_sync_q;
  logic       done_seen_q;
  logic       req_tgl_q;
  logic [2:0] goal_code_q;
  logic       cmd_busy_q;
  logic       busy_q;
  logic [3:0] tap_state_q;
  logic       sw_reset;
  logic       host_rst;
  logic       blocked;
  logic       accept;
  logic       done_evt;

  // Link domain signals
  localparam int unsigned NSYNC = 6;
  logic [1:0]       trst_sync_q;
  logic [NSYNC-1:0] in_sync1_q;
  logic [NSYNC-1:0] in_sync2_q;
  logic             req_seen_q;
  logic             done_tgl_q;
  logic             active_q;
  logic             cmd_run_q;
  logic             parked_q;
  tsg_tap_state_type goal_st_q;
  logic [2:0]       wait_q;
  logic             tms_q;
  logic             trst;
  logic             en_s;
  logic             dmode_s;
  logic             dtms_s;
  logic             stall_s;
  logic             gated_s;
  logic             req_s;
  tsg_tap_state_type st_now;
  tsg_tap_state_type st;
  tsg_tap_state_type launch_goal;
  tsg_tap_state_type cur_goal;
  logic             ready_w;
  logic             launch_cmd;
  logic             park_go;
  logic             unpark_go;
  logic             launching;
  logic             run;
  logic             finish;
  logic             finish_evt;
  logic             tms_d;

  assign sw_reset = ref_clk_en_in & command_valid_in & command_in[CMD_SOFTWARE_RESET_BIT];
  assign host_rst = reset_in | sw_reset; // RULE_10
  assign blocked  = rst_hold_q | ack_sync_q[1];
  assign done_evt = done_sync_q[1] != done_seen_q;
  assign accept   = ref_clk_en_in & command_valid_in & ~command_in[CMD_SOFTWARE_RESET_BIT] & ~cmd_busy_q
                    & ~blocked & ~discrete_mode_in & goal_valid(command_in[CMD_GOAL_MSB:CMD_GOAL_LSB]);

  // Crossings into the host domain
  always_ff @(posedge ref_clk_in) begin
    ack_sync_q  <= {ack_sync_q[0], trst_sync_q[1]};
    done_sync_q <= {done_sync_q[0], done_tgl_q};
  end

  // Reset request held until the link domain acknowledges it
  always_ff @(posedge ref_clk_in) begin
    if (host_rst) begin
      rst_hold_q <= 1'b1; // RULE_10
    end else if (ref_clk_en_in && ack_sync_q[1]) begin
      rst_hold_q <= 1'b0;
    end
  end

  // Command acceptance and completion
  always_ff @(posedge ref_clk_in) begin
    if (host_rst) begin
      req_tgl_q   <= 1'b0;
      goal_code_q <= GOAL_RESET;
      cmd_busy_q  <= 1'b0;
      done_seen_q <= 1'b0;
    end else if (ref_clk_en_in) begin
      done_seen_q <= done_sync_q[1];
      if (accept) begin
        req_tgl_q   <= ~req_tgl_q;
        goal_code_q <= command_in[CMD_GOAL_MSB:CMD_GOAL_LSB];
        cmd_busy_q  <= 1'b1;
      end else if (done_evt && !blocked) begin
        cmd_busy_q  <= 1'b0;
      end
    end
  end

  // Status outputs
  always_ff @(posedge ref_clk_in) begin
    if (host_rst) begin
      busy_q      <= 1'b1;
      tap_state_q <= TAP_RESET;
    end else if (ref_clk_en_in) begin
      busy_q <= blocked | accept | (cmd_busy_q & ~(done_evt & ~blocked));
      if (done_evt && !blocked && cmd_busy_q) begin
        tap_state_q <= goal_state(goal_code_q);
      end
    end
  end

  assign busy_out      = busy_q;
  assign tap_state_out = tap_state_q;

  // Crossings into the link domain
  always_ff @(posedge tck_in) begin
    trst_sync_q <= {trst_sync_q[0], rst_hold_q};
    in_sync1_q  <= {req_tgl_q, gated_tck_mode_in, buffer_stall_in, discrete_tms_in, discrete_mode_in, ref_clk_en_in};
    in_sync2_q  <= in_sync1_q;
  end

  assign trst    = trst_sync_q[1];
  assign en_s    = in_sync2_q[0];
  assign dmode_s = in_sync2_q[1];
  assign dtms_s  = in_sync2_q[2];
  assign stall_s = in_sync2_q[3];
  assign gated_s = in_sync2_q[4];
  assign req_s   = in_sync2_q[5];

  tsg_tap_model u_model (
    .tck_in         (tck_in),
    .reset_in       (trst),
    .enable_in      (en_s),
    .tms_in         (tms_q),
    .state_out      (st_now),
    .next_state_out (st)
  );

  assign ready_w    = ~active_q & (wait_q == WAIT_DONE) & ~dmode_s;
  assign launch_cmd = ready_w & (req_s != req_seen_q);
  assign park_go    = ready_w & (req_s == req_seen_q) & stall_s & ~gated_s & ~parked_q
                      & ((st == TAP_SHIFT_DR) | (st == TAP_SHIFT_IR)); // RULE_17
  assign unpark_go  = ready_w & (req_s == req_seen_q) & parked_q & ~stall_s; // RULE_17
  assign launching  = launch_cmd | park_go | unpark_go;

  always_comb begin
    if (launch_cmd) begin
      launch_goal = goal_state(goal_code_q);
    end else if (park_go) begin
      launch_goal = (st == TAP_SHIFT_DR) ? TAP_PAUSE_DR : TAP_PAUSE_IR;
    end else begin
      launch_goal = (goal_st_q == TAP_PAUSE_DR) ? TAP_SHIFT_DR : TAP_SHIFT_IR;
    end
  end

  assign cur_goal   = launching ? launch_goal : goal_st_q;
  assign run        = launching | active_q;
  assign finish     = (st == cur_goal) & ~(launching & is_pause(cur_goal));
  assign finish_evt = run & (finish | dmode_s);

  // TMS for the next rising edge
  always_comb begin
    if (dmode_s) begin
      tms_d = dtms_s; // RULE_18
    end else if (wait_q != WAIT_DONE) begin
      tms_d = 1'b1; // RULE_10
    end else if (run && !finish) begin
      tms_d = route(st, cur_goal, launching); // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
    end else begin
      tms_d = (st == TAP_RESET); // RULE_19
    end
  end

  // Sequence control
  always_ff @(posedge tck_in) begin
    if (trst) begin
      tms_q      <= 1'b1;
      wait_q     <= RESET_TMS_EDGES;
      req_seen_q <= 1'b0;
      done_tgl_q <= 1'b0;
      active_q   <= 1'b0;
      cmd_run_q  <= 1'b0;
      parked_q   <= 1'b0;
      goal_st_q  <= TAP_RESET;
    end else if (en_s) begin
      tms_q    <= tms_d;
      active_q <= run & ~finish_evt;
      if (wait_q != WAIT_DONE) begin
        wait_q <= wait_q - WAIT_STEP;
      end
      if (launch_cmd) begin
        req_seen_q <= req_s;
      end
      if (launching) begin
        goal_st_q <= launch_goal;
        cmd_run_q <= launch_cmd;
      end
      if (park_go) begin
        parked_q <= 1'b1; // RULE_17
      end else if (unpark_go || launch_cmd) begin
        parked_q <= 1'b0;
      end
      if (finish_evt && (launching ? launch_cmd : cmd_run_q)) begin
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  assign tms_out = tms_q;

endmodule // tsg_tap_state_generator

`default_nettype wire

// ===== sim/tsg_target_tap.sv
// Behavioural target TAP controller following the generator's TMS
`default_nettype none

module tsg_target_tap
  import tsg_pkg::*;
(
  // Link
  input  wire logic            tck_in,
  input  wire logic            tms_in,
  // Observed controller state
  output var tsg_tap_state_type state_out,
  // Scan output driver enable
  output var logic              tdo_en_out
);
  timeunit 1ns;
  timeprecision 1ps;

  tsg_tap_state_type state_q = TAP_RESET;
  tsg_tap_state_type state_d;

  // Scan registers of the target; opcode and capture value arbitrary
  localparam logic [7:0] IDCODE_OP   = 8'h01;
  localparam logic [7:0] CAPTURE_VAL = 8'hA5;
  logic [7:0] ir_q     = 8'h00;
  logic [7:0] dr_q     = 8'h00;
  logic       tdo_en_q = 1'b0;

  // Sixteen states; selects left next cycle; exits may re-enter shift
  always_comb begin
    case (state_q)
      TAP_RESET:                   state_d = tms_in ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:                    state_d = tms_in ? TAP_SELECT_DATA_SCAN : TAP_IDLE;
      TAP_SELECT_DATA_SCAN:        state_d = tms_in ? TAP_SELECT_INSTRUCTION_SCAN : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR:              state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:                state_d = tms_in ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:                state_d = tms_in ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:                state_d = tms_in ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:                state_d = tms_in ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_SELECT_INSTRUCTION_SCAN: state_d = tms_in ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR:              state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:                state_d = tms_in ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:                state_d = tms_in ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:                state_d = tms_in ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:                state_d = tms_in ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      default:                     state_d = tms_in ? TAP_SELECT_DATA_SCAN : TAP_IDLE;
    endcase
  end

  // Moves only on rising TCK
  always_ff @(posedge tck_in) begin
    state_q <= state_d;
  end

  // Only the register of the current path moves
  always_ff @(posedge tck_in) begin
    if (state_q == TAP_RESET) begin
      ir_q <= IDCODE_OP;
    end else if (state_q == TAP_SHIFT_IR) begin
      ir_q <= {1'b1, ir_q[7:1]};
    end
    if (state_q == TAP_CAPTURE_DR) begin
      dr_q <= CAPTURE_VAL;
    end else if (state_q == TAP_SHIFT_DR) begin
      dr_q <= {1'b0, dr_q[7:1]};
    end
  end

  // Output driver switches at the falling edge
  always_ff @(negedge tck_in) begin
    tdo_en_q <= (state_q == TAP_SHIFT_DR) || (state_q == TAP_SHIFT_IR);
  end

  assign state_out  = state_q;
  assign tdo_en_out = tdo_en_q;
endmodule // tsg_target_tap

`default_nettype wire

// ===== sim/tsg_tap_state_generator_checker.sv
// Port assertions of the TMS sequence generator
`default_nettype none

module tsg_tap_state_generator_checker
  import tsg_pkg::*;
(
  // Host side
  input wire logic                 ref_clk_in,
  input wire logic                 reset_in,
  input wire logic                 ref_clk_en_in,
  input wire logic                 command_valid_in,
  input wire logic [CMD_WIDTH-1:0] command_in,
  input wire logic                 busy_out,
  input wire logic [3:0]           tap_state_out,
  // Modes
  input wire logic                 discrete_mode_in,
  input wire logic                 discrete_tms_in,
  input wire logic                 buffer_stall_in,
  input wire logic                 gated_tck_mode_in,
  // Link
  input wire logic                 tck_in,
  input wire logic                 tms_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  logic cmd_ok;
  assign cmd_ok = ref_clk_en_in && command_valid_in && !command_in[CMD_SOFTWARE_RESET_BIT] && !busy_out
                  && !discrete_mode_in && (command_in[CMD_GOAL_MSB:CMD_GOAL_LSB] <= GOAL_PAUSE_IR);

  chk_cmd_sets_busy: assert property (cmd_ok |=> busy_out)
    else $error("command did not raise busy");
  chk_software_reset_bit_busy: assert property (ref_clk_en_in && command_valid_in && command_in[CMD_SOFTWARE_RESET_BIT]
    |=> busy_out)
    else $error("software reset did not raise busy");
  chk_reset_busy: assert property ($fell(reset_in) |-> ##[0:1] busy_out)
    else $error("reset handoff without busy");
  chk_state_hold: assert property (!busy_out && !$past(busy_out) && !$past(reset_in) |-> $stable(tap_state_out))
    else $error("state changed while idle");
  chk_goal_stable: assert property ($fell(busy_out) |-> tap_state_out inside {TAP_RESET, TAP_IDLE,
    TAP_SHIFT_DR, TAP_PAUSE_DR, TAP_SHIFT_IR, TAP_PAUSE_IR})
    else $error("finished in a transient state");
  chk_done_tms: assert property ($fell(busy_out) && !discrete_mode_in |-> tms_out == (tap_state_out == TAP_RESET))
    else $error("wrong held TMS level");
  chk_discrete_high: assert property ((ref_clk_en_in && discrete_mode_in && discrete_tms_in)[*8] |-> tms_out)
    else $error("TMS not following discrete high");
  chk_discrete_low: assert property ((ref_clk_en_in && discrete_mode_in && !discrete_tms_in)[*8] |-> !tms_out)
    else $error("TMS not following discrete low");
  chk_gated_hold: assert property ((gated_tck_mode_in && buffer_stall_in && !busy_out && !discrete_mode_in
    && tap_state_out == TAP_SHIFT_DR)[*8] |-> !tms_out)
    else $error("gated stall left shift");

  cov_pause_ir: cover property ($fell(busy_out) && tap_state_out == TAP_PAUSE_IR);
  cov_discrete: cover property (discrete_mode_in && discrete_tms_in && tms_out);
  cov_free_stall: cover property (buffer_stall_in && !gated_tck_mode_in && !busy_out);
endmodule // tsg_tap_state_generator_checker

bind tsg_tap_state_generator tsg_tap_state_generator_checker chk_u (
  .ref_clk_in        (ref_clk_in),
  .reset_in          (reset_in),
  .ref_clk_en_in     (ref_clk_en_in),
  .command_valid_in  (command_valid_in),
  .command_in        (command_in),
  .busy_out          (busy_out),
  .tap_state_out     (tap_state_out),
  .discrete_mode_in  (discrete_mode_in),
  .discrete_tms_in   (discrete_tms_in),
  .buffer_stall_in   (buffer_stall_in),
  .gated_tck_mode_in (gated_tck_mode_in),
  .tck_in            (tck_in),
  .tms_out           (tms_out)
);

`default_nettype wire

// ===== sim/tsg_tap_state_generator_tb.sv
// Self-checking bench of the TMS sequence generator
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t %h %h", $time, g, e); end end

module tsg_tap_state_generator_tb
  import tsg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_in = 1'b0, tck_in = 1'b0, reset_in = 1'b1, ref_clk_en_in = 1'b1;
  logic command_valid_in = 1'b0, discrete_mode_in = 1'b0, discrete_tms_in = 1'b0;
  logic buffer_stall_in = 1'b0, gated_tck_mode_in = 1'b0, busy_out, tms_out;
  logic [CMD_WIDTH-1:0] command_in = 8'h00;
  logic [3:0] tap_state_out;
  tsg_tap_state_type tgt_state;
  logic tgt_tdo_en;
  int n_mismatch = 0, checks = 0;
  tsg_tap_state_type goal_tab [6] = '{TAP_RESET, TAP_IDLE, TAP_SHIFT_DR, TAP_PAUSE_DR, TAP_SHIFT_IR, TAP_PAUSE_IR};
  logic [2:0] exit_goal [4] = '{GOAL_RESET, GOAL_IDLE, GOAL_PAUSE_DR, GOAL_PAUSE_IR};

  always #5 ref_clk_in = ~ref_clk_in;
  initial begin
    #3;
    forever #6 tck_in = ~tck_in;
  end

  tsg_tap_state_generator dut_u (
    .ref_clk_in        (ref_clk_in),
    .reset_in          (reset_in),
    .ref_clk_en_in     (ref_clk_en_in),
    .command_valid_in  (command_valid_in),
    .command_in        (command_in),
    .busy_out          (busy_out),
    .tap_state_out     (tap_state_out),
    .discrete_mode_in  (discrete_mode_in),
    .discrete_tms_in   (discrete_tms_in),
    .buffer_stall_in   (buffer_stall_in),
    .gated_tck_mode_in (gated_tck_mode_in),
    .tck_in            (tck_in),
    .tms_out           (tms_out)
  );
  tsg_target_tap tgt_u (.tck_in(tck_in), .tms_in(tms_out), .state_out(tgt_state), .tdo_en_out(tgt_tdo_en));

  task automatic print_verdict();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wait_idle();
    int i = 0;
    tick(2);
    while (busy_out !== 1'b0 && i < 400) begin
      tick(1);
      i++;
    end
    `CHK(busy_out, 1'b0)
  endtask

  task automatic send(input logic [7:0] cmd);
    @(posedge ref_clk_in);
    command_valid_in <= 1'b1;
    command_in <= cmd;
    @(posedge ref_clk_in);
    command_valid_in <= 1'b0;
    wait_idle();
  endtask

  task automatic go(input logic [2:0] goal);
    send({5'h00, goal});
    `CHK(tap_state_out, goal_tab[goal])
    `CHK(tgt_state, goal_tab[goal])
    `CHK(tms_out, goal == GOAL_RESET)
    `CHK(tgt_tdo_en, goal inside {GOAL_SHIFT_DR, GOAL_SHIFT_IR})
  endtask

  task automatic check_tlr();
    tick(12);
    `CHK(tgt_state, TAP_RESET)
    `CHK(tap_state_out, TAP_RESET)
    `CHK(tms_out, 1'b1)
    `CHK(tgt_u.ir_q, tgt_u.IDCODE_OP)
  endtask

  task automatic sw_reset();
    send(8'h80);
    check_tlr();
  endtask

  task automatic test_from_pause_ir();
    for (int g = 0; g < 6; g++) begin
      sw_reset();
      go(GOAL_PAUSE_IR);
      go(3'(g));
      if (g == GOAL_PAUSE_DR) `CHK(tgt_u.dr_q, tgt_u.CAPTURE_VAL)
    end
  endtask

  task automatic test_from_shift();
    for (int s = 0; s < 2; s++) begin
      for (int g = 0; g < 4; g++) begin
        sw_reset();
        go(GOAL_PAUSE_IR);
        go(s != 0 ? GOAL_SHIFT_IR : GOAL_SHIFT_DR);
        go(exit_goal[g]);
      end
    end
  endtask

  task automatic test_stall();
    sw_reset();
    go(GOAL_PAUSE_IR);
    go(GOAL_SHIFT_DR);
    @(posedge ref_clk_in);
    buffer_stall_in <= 1'b1;
    tick(20);
    `CHK(tgt_state, TAP_PAUSE_DR)
    @(posedge ref_clk_in);
    buffer_stall_in <= 1'b0;
    tick(20);
    `CHK(tgt_state, TAP_SHIFT_DR)
    @(posedge ref_clk_in);
    gated_tck_mode_in <= 1'b1;
    buffer_stall_in <= 1'b1;
    tick(20);
    `CHK(tgt_state, TAP_SHIFT_DR)
    `CHK(tms_out, 1'b0)
    @(posedge ref_clk_in);
    gated_tck_mode_in <= 1'b0;
    buffer_stall_in <= 1'b0;
  endtask

  task automatic test_discrete();
    @(posedge ref_clk_in);
    discrete_mode_in <= 1'b1;
    discrete_tms_in <= 1'b1;
    tick(10);
    `CHK(tms_out, 1'b1)
    @(posedge ref_clk_in);
    discrete_tms_in <= 1'b0;
    tick(10);
    `CHK(tms_out, 1'b0)
    send({5'h00, GOAL_PAUSE_IR});
    `CHK(tap_state_out, TAP_SHIFT_DR)
    @(posedge ref_clk_in);
    discrete_mode_in <= 1'b0;
    sw_reset();
  endtask

  task automatic test_enable();
    go(GOAL_SHIFT_IR);
    @(posedge ref_clk_in);
    ref_clk_en_in <= 1'b0;
    send({5'h00, GOAL_RESET});
    tick(20);
    `CHK(tap_state_out, TAP_SHIFT_IR)
    `CHK(tgt_state, TAP_SHIFT_IR)
    `CHK(tms_out, 1'b0)
    @(posedge ref_clk_in);
    ref_clk_en_in <= 1'b1;
    tick(10);
    `CHK(busy_out, 1'b0)
    `CHK(tgt_state, TAP_SHIFT_IR)
  endtask

  task automatic test_hw_reset();
    go(GOAL_PAUSE_IR);
    @(posedge ref_clk_in);
    command_valid_in <= 1'b1;
    command_in <= {5'h00, GOAL_SHIFT_DR};
    @(posedge ref_clk_in);
    command_valid_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b1;
    @(posedge ref_clk_in);
    reset_in <= 1'b0;
    wait_idle();
    check_tlr();
  endtask

  initial begin
    repeat (6) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    wait_idle();
    check_tlr();
    test_from_pause_ir();
    test_from_shift();
    test_stall();
    test_discrete();
    test_enable();
    test_hw_reset();
    print_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule // tsg_tap_state_generator_tb

`default_nettype wire
